// file: verilog/dcts_top.v
// dual channel transmit serializer: config latches, capture, align, bist, shifter
`timescale 1ns/1ns
`include "dcts_map.vh"

module dcts_top
(
   // clock and reset
   input wire pclk,
   input wire presetn,
   // apb slave
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [5:0] paddr,
   input wire [31:0] pwdata,
   output wire pready,
   output wire [31:0] prdata,
   output wire pslverr,
   // configuration pins
   input wire cfg_write_n,
   input wire [3:0] cfg_data,
   input wire [2:0] cfg_addr,
   // per channel clocks and pins, channel a in bit 0
   input wire [1:0] ref_clk_in,
   input wire [1:0] ext_tx_clk,
   input wire [19:0] par_char_in,
   input wire [3:0] speed_range_sel,
   // per channel outputs
   output wire [1:0] char_clk_out,
   output wire [1:0] align_err_out,
   output wire [1:0] ser_out1,
   output wire [1:0] ser_out2,
   output wire [1:0] ser_bit_stb,
   output wire [1:0] chan_pwr_dn,
   output wire [1:0] cfg_reserved,
   output wire [9:0] bit_rate_mult
);

   // ----------------------------------------------------------------
   // functions
   // ----------------------------------------------------------------
   // bank number of a channel's latch bank
   function [2:0] bank_of;
      input ch;
      input [1:0] idx;
      begin
         bank_of = ch ? (`DCTS_BANK_B0 + {1'b0, idx}) : (`DCTS_BANK_A0 + {1'b0, idx});
      end
   endfunction

   // one step of x^9 + x^5 + 1
   function [8:0] lfsr_step;
      input [8:0] s;
      begin
         lfsr_step = {s[7:0], s[8] ^ s[4]};
      end
   endfunction

   // ----------------------------------------------------------------
   // input synchronisers
   // ----------------------------------------------------------------
   wire [1:0] ref_s;
   wire [1:0] ext_s;
   wire [19:0] par_s;
   wire [7:0] cfg_s;

   dcts_sync #(.W(4)) u_clk_sync
   (
      .pclk(pclk),
      .presetn(presetn),
      .d({ext_tx_clk, ref_clk_in}),
      .q({ext_s, ref_s})
   );

   dcts_sync #(.W(28)) u_pin_sync
   (
      .pclk(pclk),
      .presetn(presetn),
      .d({~cfg_write_n, cfg_addr, cfg_data, par_char_in}),
      .q({cfg_s, par_s})
   );

   // ----------------------------------------------------------------
   // configuration latch banks
   // ----------------------------------------------------------------
   reg [31:0] lat_q;
   reg [31:0] lat_d;
   reg [1:0] init_q;
   reg [1:0] init_d;
   wire pin_wr;
   wire [2:0] pin_bank;
   wire [3:0] pin_data;
   wire apb_wr;
   wire apb_bank_hit;
   wire [2:0] apb_bank;
   integer i;

   assign pin_wr = cfg_s[7];
   assign pin_bank = cfg_s[6:4];
   assign pin_data = cfg_s[3:0];
   assign apb_bank_hit = (paddr[5] == 1'b0) && (paddr[1:0] == 2'h0);
   assign apb_bank = paddr[4:2];
   assign apb_wr = psel & penable & pwrite & apb_bank_hit;

   always @*
   begin
      lat_d = lat_q;
      init_d = 2'h0;
      // pin writes store while the write enable is held low
      if (pin_wr)
         lat_d[{pin_bank, 2'h0} +: 4] = pin_data;
      if (apb_wr)
         lat_d[{apb_bank, 2'h0} +: 4] = pwdata[3:0];
      // test banks hold no state
      lat_d[{`DCTS_BANK_T3, 2'h0} +: 4] = 4'h0;
      lat_d[{`DCTS_BANK_T4, 2'h0} +: 4] = 4'h0;
      for (i = 0; i < 2; i = i + 1)
      begin
         // a zero written to the align reset bit starts initialization
         if (pin_wr && pin_bank == bank_of(i[0], 2'h2) && !pin_data[`DCTS_F_PABRST])
            init_d[i] = 1'b1;
         if (apb_wr && apb_bank == bank_of(i[0], 2'h2) && !pwdata[`DCTS_F_PABRST])
            init_d[i] = 1'b1;
      end
   end

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         // ref clock capture, bist off, drivers off
         lat_q <= `DCTS_LAT_RST;
         init_q <= 2'h0;
      end
      else
      begin
         lat_q <= lat_d;
         init_q <= init_d;
      end
   end

   // ----------------------------------------------------------------
   // apb read and response
   // ----------------------------------------------------------------
   reg [31:0] rdata;
   wire [31:0] status;

   assign status = {24'h0, cfg_reserved, chan_pwr_dn, 2'h0, align_err_out};
   assign pready = 1'b1;
   assign pslverr = psel & penable & ~apb_bank_hit & ~(paddr == `DCTS_STATUS_ADDR && !pwrite);

   always @*
   begin
      rdata = 32'h0;
      if (apb_bank_hit)
         rdata = {28'h0, lat_q[{apb_bank, 2'h0} +: 4]};
      else if (paddr == `DCTS_STATUS_ADDR)
         rdata = status;
   end

   assign prdata = (psel & penable & ~pwrite) ? rdata : 32'h0;

   // ----------------------------------------------------------------
   // channels
   // ----------------------------------------------------------------
   genvar ch;
   generate
      for (ch = 0; ch < 2; ch = ch + 1)
      begin : g_ch
         wire [3:0] bank0;
         wire [3:0] bank1;
         wire [3:0] bank2;
         wire cksel;
         wire rate;
         wire drv1;
         wire drv2;
         wire bist_on;
         wire pwr_on;
         wire ref_rise;
         wire ref_fall;
         wire ext_rise;
         wire char_stb;
         wire buf_err;
         wire [9:0] buf_rdata;
         reg ref_d_q;
         reg ext_d_q;
         reg stb_d_q;
         reg [9:0] cap_q;
         reg [8:0] lfsr_q;
         reg [9:0] pend_q;
         reg pend_vld_q;
         reg [9:0] sh_q;
         reg [3:0] cnt_q;
         reg out1_q;
         reg out2_q;
         reg stb_q;
         reg cko_q;
         reg [9:0] nxt_char;

         assign bank0 = lat_q[{bank_of(ch == 1, 2'h0), 2'h0} +: 4];
         assign bank1 = lat_q[{bank_of(ch == 1, 2'h1), 2'h0} +: 4];
         assign bank2 = lat_q[{bank_of(ch == 1, 2'h2), 2'h0} +: 4];
         assign cksel = bank0[`DCTS_F_CKSEL];
         assign rate = bank0[`DCTS_F_RATE];
         assign drv1 = bank1[`DCTS_F_DRV1];
         assign drv2 = bank1[`DCTS_F_DRV2];
         assign bist_on = ~bank2[`DCTS_F_BISTN];
         // both drivers off idles the channel
         assign pwr_on = drv1 | drv2;

         // edges of the sampled clocks
         assign ref_rise = ref_s[ch] & ~ref_d_q;
         assign ref_fall = ~ref_s[ch] & ref_d_q;
         assign ext_rise = ext_s[ch] & ~ext_d_q;
         // half rate takes a character on each ref edge
         assign char_stb = pwr_on & (ref_rise | (rate & ref_fall));

         // speed range and multiplier status
         assign cfg_reserved[ch] = rate & (speed_range_sel[2*ch +: 2] == `DCTS_SPD_LOW);
         assign bit_rate_mult[5*ch +: 5] = rate ? `DCTS_MULT_HALF : `DCTS_MULT_FULL;

         // ext clock path goes through the align buffer
         dcts_align_buf u_abuf
         (
            .pclk(pclk),
            .presetn(presetn),
            .init(init_q[ch]),
            .hold(~pwr_on),
            .wr_en(ext_rise & ~cksel & ~bist_on),
            .wr_data(par_s[10*ch +: 10]),
            .rd_en(char_stb & ~cksel & ~bist_on),
            .rd_data(buf_rdata),
            .err(buf_err)
         );

         // source of the next character
         always @*
         begin
            nxt_char = buf_rdata;
            if (buf_err)
               nxt_char = `DCTS_ERR_CHAR;
            else if (bist_on)
               nxt_char = {^lfsr_q, lfsr_q};
            else if (cksel)
               nxt_char = cap_q;
         end

         always @(posedge pclk or negedge presetn)
         begin
            if (!presetn)
            begin
               ref_d_q <= 1'b0;
               ext_d_q <= 1'b0;
               stb_d_q <= 1'b0;
               cap_q <= 10'h000;
               lfsr_q <= `DCTS_LFSR_SEED;
               pend_q <= 10'h000;
               pend_vld_q <= 1'b0;
               cko_q <= 1'b0;
            end
            else
            begin
               ref_d_q <= ref_s[ch];
               ext_d_q <= ext_s[ch];
               stb_d_q <= char_stb;
               cko_q <= char_stb;
               // ref clock capture of parallel input
               if (char_stb && cksel && !bist_on)
                  cap_q <= par_s[10*ch +: 10];
               // 511-character sequence, seed shared with the receiver
               if (!bist_on)
                  lfsr_q <= `DCTS_LFSR_SEED;
               else if (stb_d_q)
                  lfsr_q <= lfsr_step(lfsr_q);
               if (stb_d_q)
               begin
                  pend_q <= nxt_char;
                  pend_vld_q <= 1'b1;
               end
               else if (cnt_q == 4'h0 || !pwr_on)
                  pend_vld_q <= 1'b0;
            end
         end

         // transmit shifter, lsb first
         always @(posedge pclk or negedge presetn)
         begin
            if (!presetn)
            begin
               sh_q <= 10'h000;
               cnt_q <= 4'h0;
               out1_q <= 1'b0;
               out2_q <= 1'b0;
               stb_q <= 1'b0;
            end
            else if (!pwr_on)
            begin
               sh_q <= 10'h000;
               cnt_q <= 4'h0;
               out1_q <= 1'b0;
               out2_q <= 1'b0;
               stb_q <= 1'b0;
            end
            else
            begin
               stb_q <= 1'b0;
               if (cnt_q == 4'h0 && pend_vld_q && !stb_d_q)
               begin
                  sh_q <= pend_q;
                  cnt_q <= `DCTS_BITS_PER_CHAR;
               end
               else if (cnt_q != 4'h0)
               begin
                  // each driver gated by its own enable
                  out1_q <= drv1 & sh_q[0];
                  out2_q <= drv2 & sh_q[0];
                  stb_q <= 1'b1;
                  sh_q <= {1'b0, sh_q[9:1]};
                  cnt_q <= cnt_q - 4'h1;
               end
            end
         end

         assign char_clk_out[ch] = cko_q;
         assign align_err_out[ch] = buf_err;
         assign ser_out1[ch] = out1_q;
         assign ser_out2[ch] = out2_q;
         assign ser_bit_stb[ch] = stb_q;
         assign chan_pwr_dn[ch] = ~pwr_on;
      end
   endgenerate

endmodule

// file: common/dcts_map.vh
// constants for the dual channel transmit serializer
`ifndef DCTS_MAP_VH
`define DCTS_MAP_VH

// ----------------------------------------------------------------
// character and clocking
// ----------------------------------------------------------------
`define DCTS_CHAR_W 10
`define DCTS_ERR_CHAR 10'h278
`define DCTS_BITS_PER_CHAR 4'ha
`define DCTS_LFSR_SEED 9'h1ff
`define DCTS_MULT_FULL 5'h0a
`define DCTS_MULT_HALF 5'h14

// ----------------------------------------------------------------
// latch banks: bank n at byte address 4*n
// ----------------------------------------------------------------
`define DCTS_BANKS 8
`define DCTS_BANK_A0 3'h0
`define DCTS_BANK_A1 3'h1
`define DCTS_BANK_A2 3'h2
`define DCTS_BANK_T3 3'h3
`define DCTS_BANK_T4 3'h4
`define DCTS_BANK_B0 3'h5
`define DCTS_BANK_B1 3'h6
`define DCTS_BANK_B2 3'h7
`define DCTS_LAT_RST 32'h3010_0301
`define DCTS_STATUS_ADDR 6'h20

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
// static bank 0 of a channel
`define DCTS_F_CKSEL 0
`define DCTS_F_RATE 1
// static bank 1 of a channel
`define DCTS_F_DRV1 0
`define DCTS_F_DRV2 1
// dynamic bank 2 of a channel
`define DCTS_F_BISTN 0
`define DCTS_F_PABRST 1

// ----------------------------------------------------------------
// speed range select codes
// ----------------------------------------------------------------
`define DCTS_SPD_LOW 2'h0
`define DCTS_SPD_MID 2'h1
`define DCTS_SPD_HIGH 2'h2

// ----------------------------------------------------------------
// phase-align buffer
// ----------------------------------------------------------------
`define DCTS_ABUF_AW 2
`define DCTS_ABUF_INIT_FILL 3'h2
`define DCTS_ABUF_FULL 3'h4

`endif

// file: verilog/dcts_sync.v
// two-stage synchroniser for inputs from outside the pclk domain
`timescale 1ns/1ns
`include "dcts_map.vh"

module dcts_sync
#(
   parameter W = 1
)
(
   // clock and reset
   input wire pclk,
   input wire presetn,
   // data
   input wire [W-1:0] d,
   output wire [W-1:0] q
);

   reg [W-1:0] meta_q;
   reg [W-1:0] sync_q;

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         meta_q <= {W{1'b0}};
         sync_q <= {W{1'b0}};
      end
      else
      begin
         meta_q <= d;
         sync_q <= meta_q;
      end
   end

   assign q = sync_q;

endmodule

// file: verilog/dcts_align_buf.v
// phase-align buffer: four character slots with overflow error
`timescale 1ns/1ns
`include "dcts_map.vh"

module dcts_align_buf
(
   // clock and reset
   input wire pclk,
   input wire presetn,
   // control
   input wire init,
   input wire hold,
   // write side
   input wire wr_en,
   input wire [9:0] wr_data,
   // read side
   input wire rd_en,
   output wire [9:0] rd_data,
   // status
   output wire err
);

   reg [9:0] mem_q [0:3];
   reg [9:0] rd_data_q;
   reg [1:0] wp_q;
   reg [1:0] rp_q;
   reg [2:0] fill_q;
   reg err_q;
   wire do_wr;
   wire do_rd;
   wire ovf;

   // slips in either direction mean lost characters
   assign do_wr = wr_en & ~hold;
   assign do_rd = rd_en & ~hold;
   assign ovf = (do_wr & ~do_rd & (fill_q == `DCTS_ABUF_FULL)) | (do_rd & ~do_wr & (fill_q == 3'h0));

   always @(posedge pclk)
   begin
      if (do_wr)
         mem_q[wp_q] <= wr_data;
   end

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         wp_q <= 2'h0;
         rp_q <= 2'h0;
         fill_q <= 3'h0;
         err_q <= 1'b0;
         rd_data_q <= 10'h000;
      end
      else if (init)
      begin
         // centre the window: two characters of slack each way
         wp_q <= rp_q + 2'h2;
         fill_q <= `DCTS_ABUF_INIT_FILL;
         err_q <= ovf;
      end
      else
      begin
         if (do_wr && !ovf)
            wp_q <= wp_q + 2'h1;
         if (do_rd && !ovf)
         begin
            rp_q <= rp_q + 2'h1;
            rd_data_q <= mem_q[rp_q];
         end
         if (!ovf)
            fill_q <= fill_q + {2'h0, do_wr} - {2'h0, do_rd};
         if (ovf)
            err_q <= 1'b1;
      end
   end

   assign rd_data = rd_data_q;
   assign err = err_q;

endmodule

// file: testbench/dcts_props.sv
// assertion checker for the dual channel transmit serializer
`timescale 1ns/1ns
`include "dcts_map.vh"
module dcts_props
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // bus and pins
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic pslverr,
   input wire logic [5:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic cfg_write_n,
   input wire logic [3:0] cfg_data,
   input wire logic [2:0] cfg_addr,
   input wire logic [3:0] speed_range_sel,
   // channel outputs
   input wire logic [1:0] char_clk_out,
   input wire logic [1:0] align_err_out,
   input wire logic [1:0] ser_out1,
   input wire logic [1:0] ser_bit_stb,
   input wire logic [1:0] chan_pwr_dn,
   input wire logic [1:0] cfg_reserved,
   input wire logic [9:0] bit_rate_mult
);
   localparam logic [9:0] ERRC = `DCTS_ERR_CHAR;
   logic [3:0] run_q;
   logic [2:0] since_init_q;
   wire init_req;
   // any request that reinitializes the channel a align buffer
   assign init_req = (psel && penable && pwrite && paddr == {`DCTS_BANK_A2, 2'h0} && !pwdata[`DCTS_F_PABRST])
      || (!cfg_write_n && cfg_addr == `DCTS_BANK_A2 && !cfg_data[`DCTS_F_PABRST]);
   // length of the current strobe run and cycles since the last init request
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         run_q <= 4'h0;
         since_init_q <= 3'h7;
      end
      else
      begin
         run_q <= ser_bit_stb[0] ? run_q + 4'h1 : 4'h0;
         if (init_req)
            since_init_q <= 3'h0;
         else if (since_init_q != 3'h7)
            since_init_q <= since_init_q + 3'h1;
      end
   end
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   a_pwr_dn_quiet: assert property (chan_pwr_dn[0] |=> !ser_out1[0] && !ser_bit_stb[0])
      else $error("serial activity on a powered-down channel");
   a_char_pulse: assert property (char_clk_out[0] |=> (!char_clk_out[0])[*6])
      else $error("character strobe too long or too close");
   a_ten_bits: assert property (ser_bit_stb[0] |-> run_q < 4'ha)
      else $error("character longer than ten bits");
   a_ten_bit_end: assert property ($fell(ser_bit_stb[0]) && !chan_pwr_dn[0] |-> run_q == 4'ha)
      else $error("character shorter than ten bits");
   a_err_sticky: assert property (align_err_out[0] && since_init_q == 3'h7 && !init_req |=> align_err_out[0])
      else $error("align error dropped without init");
   a_err_char_sent: assert property ($rose(ser_bit_stb[0]) && align_err_out[0] && $past(align_err_out[0], 4)
      && $past(align_err_out[0], 16) |-> ser_out1[0] == ERRC[0] ##1 ser_out1[0] == ERRC[1]
      ##1 ser_out1[0] == ERRC[2] ##1 ser_out1[0] == ERRC[3] ##1 ser_out1[0] == ERRC[4] ##1 ser_out1[0] == ERRC[5]
      ##1 ser_out1[0] == ERRC[6] ##1 ser_out1[0] == ERRC[7] ##1 ser_out1[0] == ERRC[8] ##1 ser_out1[0] == ERRC[9])
      else $error("wrong character sent during align error");
   a_reserved_mode: assert property (cfg_reserved[0] |->
      speed_range_sel[1:0] == `DCTS_SPD_LOW && bit_rate_mult[4:0] == 5'd20)
      else $error("reserved flag without low speed and half rate");
   a_err_in_access: assert property (pslverr |-> psel && penable)
      else $error("bus error outside access phase");
   a_rdata_idle: assert property (!(psel && penable && !pwrite) |-> prdata == 32'h0)
      else $error("read data outside read access");
   a_reset_state: assert property ($rose(presetn) |-> chan_pwr_dn == 2'b11 && align_err_out == 2'b00)
      else $error("wrong state after reset");
   a_pin_write: assert property ($fell(cfg_write_n) && cfg_addr == `DCTS_BANK_B1 && cfg_data[1:0] != 2'h0
      |-> ##[2:4] !chan_pwr_dn[1])
      else $error("pin write did not reach latch bank");
   c_err: cover property ($rose(align_err_out[0]));
   c_err_clear: cover property ($fell(align_err_out[0]));
   c_reserved: cover property (cfg_reserved[0]);
endmodule
bind dcts_top dcts_props dcts_props_i (.pclk, .presetn, .psel, .penable, .pwrite, .pslverr, .paddr, .pwdata,
   .prdata, .cfg_write_n,
   .cfg_data, .cfg_addr, .speed_range_sel, .char_clk_out, .align_err_out, .ser_out1, .ser_bit_stb, .chan_pwr_dn,
   .cfg_reserved, .bit_rate_mult);

// file: testbench/dcts_link.sv
// link partner: clock and character source plus serial receiver
`timescale 1ns/1ns
module dcts_link
#(
   parameter int REF_HALF = 64
)
(
   // bench control
   input wire logic pclk,
   input wire logic ext_fast,
   input wire logic [9:0] char_val,
   // source side
   output logic [1:0] ref_clk_in,
   output logic [1:0] ext_tx_clk,
   output logic [19:0] par_char_in,
   // receiver side
   input wire logic [1:0] ser_out1,
   input wire logic [1:0] ser_bit_stb,
   output logic [9:0] rx_char,
   output logic rx_valid
);
   logic prev_q;
   logic [9:0] acc;
   int idx;
   // ----------------------------------------------------------------
   // clocks
   // ----------------------------------------------------------------
   initial
   begin
      ref_clk_in = 2'b00;
      forever #(REF_HALF) ref_clk_in = ~ref_clk_in;
   end
   initial
   begin
      ext_tx_clk = 2'b00;
      par_char_in = 20'h0;
      #(REF_HALF / 3);
      forever #(ext_fast ? REF_HALF / 2 : REF_HALF) ext_tx_clk = ~ext_tx_clk;
   end
   // data changes away from the capturing rising edge
   always @(negedge ext_tx_clk[0]) par_char_in <= {~char_val, char_val};
   // ----------------------------------------------------------------
   // receiver: a strobe gap starts the next character
   // ----------------------------------------------------------------
   initial
   begin
      prev_q = 1'b0;
      rx_valid = 1'b0;
      rx_char = 10'h0;
      idx = 0;
   end
   always @(posedge pclk)
   begin
      rx_valid <= 1'b0;
      prev_q <= ser_bit_stb[0];
      if (ser_bit_stb[0])
      begin
         idx = prev_q ? idx + 1 : 0;
         acc[idx] = ser_out1[0];
         if (idx == 9)
         begin
            rx_char <= acc;
            rx_valid <= 1'b1;
         end
      end
   end
endmodule

// file: testbench/test_dual_channel_tx_serializer.sv
// self-checking bench for the dual channel transmit serializer
`timescale 1ns/1ns
`include "dcts_map.vh"
module test_dual_channel_tx_serializer;
   logic pclk, presetn, psel, penable, pwrite, cfg_write_n, ext_fast;
   logic [5:0] paddr;
   logic [31:0] pwdata;
   logic [3:0] cfg_data, speed_range_sel;
   logic [2:0] cfg_addr;
   logic [9:0] char_val, first_c;
   wire pready, pslverr, rx_valid;
   wire [31:0] prdata;
   wire [1:0] ref_clk_in, ext_tx_clk, char_clk_out, align_err_out, ser_out1, ser_out2, ser_bit_stb, chan_pwr_dn;
   wire [1:0] cfg_reserved;
   wire [19:0] par_char_in;
   wire [9:0] bit_rate_mult, rx_char;
   int num_errors = 0, checks_done = 0, cyc = 0, n;
   logic [9:0] exp_q[$];
   dcts_top dcts_top_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr,
      .cfg_write_n, .cfg_data, .cfg_addr, .ref_clk_in, .ext_tx_clk, .par_char_in, .speed_range_sel, .char_clk_out,
      .align_err_out, .ser_out1, .ser_out2, .ser_bit_stb, .chan_pwr_dn, .cfg_reserved, .bit_rate_mult);
   dcts_link dcts_link_i (.pclk, .ext_fast, .char_val, .ref_clk_in, .ext_tx_clk, .par_char_in, .ser_out1,
      .ser_bit_stb, .rx_char, .rx_valid);
   // ----------------------------------------------------------------
   // checking and closing
   // ----------------------------------------------------------------
   task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         num_errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chk_char(input logic [9:0] got, input logic [9:0] exp);
      chk_val({22'h0, got}, {22'h0, exp});
   endtask
   task automatic conclude;
      if (num_errors == 0 && checks_done > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // ----------------------------------------------------------------
   // drivers
   // ----------------------------------------------------------------
   task automatic xfer(input logic w, input logic [5:0] a, input logic [31:0] d, input logic [31:0] ed,
      input logic ee);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
         @(posedge pclk);
      while (pready !== 1'b1);
      if (!w)
         chk_val(prdata, ed);
      chk_val({31'h0, pslverr}, {31'h0, ee});
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic rdb(input logic [2:0] b, input logic [31:0] e);
      xfer(1'b0, {b, 2'b00}, 32'h0, e, 1'b0);
   endtask
   task automatic wrb(input logic [2:0] b, input logic [31:0] d);
      xfer(1'b1, {b, 2'b00}, d, 32'h0, 1'b0);
   endtask
   task automatic next_char;
      do
         @(posedge pclk);
      while (rx_valid !== 1'b1);
   endtask
   task automatic expect_chars(input logic [9:0] v);
      repeat (64) @(posedge pclk);
      repeat (3) exp_q.push_back(v);
      while (exp_q.size() != 0)
         @(posedge pclk);
   endtask
   always @(posedge pclk)
   begin
      if (rx_valid === 1'b1 && exp_q.size() != 0)
         chk_char(rx_char, exp_q.pop_front());
      if (ser_bit_stb[0] === 1'b1 && exp_q.size() != 0)
         chk_val({31'h0, ser_out2[0]}, {31'h0, ser_out1[0]});
   end
   always @(posedge pclk)
   begin
      cyc++;
      if (cyc == 40000)
      begin
         num_errors++;
         conclude();
      end
   end
   initial
   begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end
   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   initial
   begin
      {presetn, psel, penable, pwrite, paddr, pwdata, ext_fast, cfg_data, cfg_addr} = '0;
      cfg_write_n = 1'b1;
      speed_range_sel = 4'h5;
      char_val = 10'h0;
      n = $urandom(53540);
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      for (int b = 0; b < 8; b++)
         rdb(3'(b), (`DCTS_LAT_RST >> (4 * b)) & 32'hf);
      xfer(1'b0, `DCTS_STATUS_ADDR, 32'h0, 32'h30, 1'b0);
      xfer(1'b0, 6'h24, 32'h0, 32'h0, 1'b1);
      xfer(1'b0, 6'h05, 32'h0, 32'h0, 1'b1);
      xfer(1'b1, `DCTS_STATUS_ADDR, 32'h3, 32'h0, 1'b1);
      cfg_addr <= `DCTS_BANK_B1;
      cfg_data <= 4'h3;
      repeat (3) @(posedge pclk);
      cfg_write_n <= 1'b0;
      repeat (5) @(posedge pclk);
      cfg_write_n <= 1'b1;
      repeat (3) @(posedge pclk);
      rdb(`DCTS_BANK_B1, 32'h3);
      wrb(`DCTS_BANK_A1, 32'h3);
      xfer(1'b0, `DCTS_STATUS_ADDR, 32'h0, 32'h0, 1'b0);
      speed_range_sel <= {2'h1, `DCTS_SPD_LOW};
      wrb(`DCTS_BANK_A0, 32'h3);
      chk_val({27'h0, bit_rate_mult[4:0]}, 32'd20);
      xfer(1'b0, `DCTS_STATUS_ADDR, 32'h0, 32'h40, 1'b0);
      speed_range_sel <= {2'h1, 2'(1 + $urandom % 2)};
      wrb(`DCTS_BANK_A0, 32'h1);
      chk_val({22'h0, bit_rate_mult}, {22'h0, 5'd10, 5'd10});
      char_val <= 10'($urandom);
      @(posedge pclk);
      expect_chars(char_val);
      wrb(`DCTS_BANK_A0, 32'h0);
      wrb(`DCTS_BANK_A2, 32'h1);
      ext_fast <= 1'b1;
      repeat (300) @(posedge pclk);
      chk_val({31'h0, align_err_out[0]}, 32'h1);
      expect_chars(`DCTS_ERR_CHAR);
      ext_fast <= 1'b0;
      wrb(`DCTS_BANK_A2, 32'h1);
      wrb(`DCTS_BANK_A2, 32'h3);
      repeat (32) @(posedge pclk);
      chk_val({31'h0, align_err_out[0]}, 32'h0);
      expect_chars(char_val);
      wrb(`DCTS_BANK_A0, 32'h1);
      wrb(`DCTS_BANK_A2, 32'h2);
      repeat (64) @(posedge pclk);
      next_char();
      first_c = rx_char;
      n = 0;
      do
      begin
         char_val <= 10'($urandom);
         next_char();
         n++;
      end
      while (rx_char !== first_c);
      chk_val(32'(n), 32'd511);
      presetn <= 1'b0;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rdb(`DCTS_BANK_A2, 32'h3);
      rdb(`DCTS_BANK_A1, 32'h0);
      conclude();
   end
endmodule
